//--- src/lpc_panel.sv
// Purpose: Local operator panel: buttons, DIP switches, green lamp, set-point shaping.
// Assumes: sp_in comes from core_clk logic; buttons and DIP switches are raw pins, high = pressed/ON.
// Notes: APB answers after two access cycles; pulses last one cycle.
// Operation
// - DIP 4 ON manual, OFF automatic
// - Panel inputs ignored while local lock set
// - Manual: button 1 held aerates
// - Manual: button 2 held deaerates
// - Both 10 to 30 s: 5 Hz, restart
// - Both over 30 s: 10 Hz, factory reset
// - Auto: button 1 5 s starts tuning
// - Auto: lamp flashes 5 Hz while button 1 stays held past 5 s
// - Direction ON: descending set-point mapping
// - Direction OFF: ascending set-point mapping
// - Seal ON: close below 2%, open above 98%
// - Lower seal threshold reprogrammable, factory default
// - DIP 3 ON: correction, OFF linear
// - DIP positions override software settings
// - Software seal/curve writes need DIP ON
// - Direction set only by its DIP
// - Untouched characteristic stays linear
//
// Chosen here: the placing of the registers and the APB register port.
module lpc_panel #(
  parameter int TICK_CYCLES = lpc_pkg::TICK_CYCLES,
  parameter int TUNE_MS = lpc_pkg::TUNE_HOLD_MS,
  parameter int RESTART_MS = lpc_pkg::RESTART_HOLD_MS,
  parameter int FACTORY_MS = lpc_pkg::FACTORY_HOLD_MS
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_b,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Panel pins
  input wire logic [1:0] button_raw,
  input wire logic [3:0] dip_raw,
  output logic green_status_lamp,
  // Set-point path
  input wire logic [lpc_pkg::SP_W-1:0] sp_in,
  output logic [lpc_pkg::SP_W-1:0] valve_setpoint,
  // Valve and system commands
  output logic manual_mode,
  output logic aerate,
  output logic deaerate,
  output logic autotune_start,
  output logic restart_req,
  output logic factory_reset_req
);
  localparam int SP_W = lpc_pkg::SP_W;

  // Millisecond time base
  logic [15:0] tick_cnt;
  logic [15:0] next_tick_cnt;
  logic tick;
  logic next_tick;
  always_comb begin
    next_tick = 1'b0;
    next_tick_cnt = tick_cnt + 16'h0001;
    if (tick_cnt >= 16'(TICK_CYCLES - 1)) begin
      next_tick_cnt = 16'h0000;
      next_tick = 1'b1;
    end
  end
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      tick_cnt <= 16'h0000;
      tick <= 1'b0;
    end else begin
      tick_cnt <= next_tick_cnt;
      tick <= next_tick;
    end
  end

  // Synchronised, debounced contacts
  logic [5:0] clean;
  lpc_debounce #(.W(6), .STABLE_TICKS(lpc_pkg::DEBOUNCE_MS)) u_debounce (
    .core_clk(core_clk),
    .rst_b(rst_b),
    .tick(tick),
    .raw({dip_raw, button_raw}),
    .clean(clean)
  );

  // Register file state
  logic lock;
  logic [SP_W-1:0] seal_lo;
  logic [SP_W-1:0] seal_hi;
  logic [1:0] char_sel;
  logic next_lock;
  logic [SP_W-1:0] next_seal_lo;
  logic [SP_W-1:0] next_seal_hi;
  logic [1:0] next_char_sel;
  logic [31:0] next_prdata;
  logic next_pready;
  logic next_pslverr;
  logic [3:0] dip_eff;
  logic [1:0] btn_eff;
  lpc_pkg::lpc_hold_type state;

  // Decode of mapped offsets
  function automatic logic is_mapped(input logic [7:0] a);
    is_mapped = (a == lpc_pkg::CTRL_OFS) || (a == lpc_pkg::SEAL_LO_OFS) || (a == lpc_pkg::SEAL_HI_OFS) ||
                (a == lpc_pkg::CHAR_SEL_OFS) || (a == lpc_pkg::STATUS_OFS);
  endfunction

  // APB access, writes land at the edge that samples pready high
  always_comb begin
    logic wr;
    wr = psel && penable && pready && pwrite;
    next_lock = lock;
    next_seal_lo = seal_lo;
    next_seal_hi = seal_hi;
    next_char_sel = char_sel;
    next_pready = psel && penable && !pready;
    next_pslverr = 1'b0;
    next_prdata = 32'h0000_0000;
    if (wr) begin
      case (paddr)
        lpc_pkg::CTRL_OFS: begin
          next_lock = pwdata[lpc_pkg::CTRL_LOCK_BIT];
        end
        lpc_pkg::SEAL_LO_OFS: begin
          if (dip_eff[lpc_pkg::DIP_SEAL]) begin
            next_seal_lo = pwdata[SP_W-1:0];
          end
        end
        lpc_pkg::SEAL_HI_OFS: begin
          if (dip_eff[lpc_pkg::DIP_SEAL]) begin
            next_seal_hi = pwdata[SP_W-1:0];
          end
        end
        lpc_pkg::CHAR_SEL_OFS: begin
          if (dip_eff[lpc_pkg::DIP_CHAR]) begin
            next_char_sel = pwdata[1:0];
          end
        end
        default: begin
        end
      endcase
    end
    if (psel && penable && !pready) begin
      next_pslverr = !is_mapped(paddr);
      case (paddr)
        lpc_pkg::CTRL_OFS: next_prdata = {31'h0000_0000, lock};
        lpc_pkg::SEAL_LO_OFS: next_prdata = {20'h0_0000, seal_lo};
        lpc_pkg::SEAL_HI_OFS: next_prdata = {20'h0_0000, seal_hi};
        lpc_pkg::CHAR_SEL_OFS: next_prdata = {30'h0000_0000, char_sel};
        lpc_pkg::STATUS_OFS: next_prdata = {22'h00_0000, state, lock, green_status_lamp, btn_eff, dip_eff};
        default: next_prdata = 32'h0000_0000;
      endcase
    end
  end
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      lock <= lpc_pkg::CTRL_LOCK_RESET;
      seal_lo <= lpc_pkg::SEAL_LO_RESET;
      seal_hi <= lpc_pkg::SEAL_HI_RESET;
      char_sel <= lpc_pkg::CHAR_SEL_RESET;
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      lock <= next_lock;
      seal_lo <= next_seal_lo;
      seal_hi <= next_seal_hi;
      char_sel <= next_char_sel;
      prdata <= next_prdata;
      pready <= next_pready;
      pslverr <= next_pslverr;
    end
  end

  // Accepted panel inputs: frozen switches and released buttons while locked
  logic [3:0] next_dip_eff;
  logic [1:0] next_btn_eff;
  always_comb begin
    next_dip_eff = lock ? dip_eff : clean[5:2];
    next_btn_eff = lock ? 2'h0 : clean[1:0];
  end
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      dip_eff <= 4'h0;
      btn_eff <= 2'h0;
    end else begin
      dip_eff <= next_dip_eff;
      btn_eff <= next_btn_eff;
    end
  end

  // Button hold sequencer and lamp flasher
  localparam int HOLD_W_L = lpc_pkg::HOLD_W;
  logic [HOLD_W_L-1:0] hold_ms;
  logic [7:0] flash_ms;
  lpc_pkg::lpc_hold_type next_state;
  logic [HOLD_W_L-1:0] next_hold_ms;
  logic [7:0] next_flash_ms;
  logic next_lamp;
  logic next_aerate;
  logic next_deaerate;
  logic next_tune;
  logic next_restart;
  logic next_factory;
  logic next_manual;
  always_comb begin
    logic both;
    logic [7:0] half;
    logic flashing;
    both = btn_eff == 2'h3;
    next_state = state;
    next_hold_ms = hold_ms;
    next_tune = 1'b0;
    next_restart = 1'b0;
    next_factory = 1'b0;
    next_manual = dip_eff[lpc_pkg::DIP_MANUAL];
    // Valve drive only in manual, single button held
    next_aerate = next_manual && btn_eff == 2'h1;
    next_deaerate = next_manual && btn_eff == 2'h2;
    if (tick && hold_ms != {HOLD_W_L{1'b1}}) begin
      next_hold_ms = hold_ms + 1'b1;
    end
    case (state)
      lpc_pkg::LPC_IDLE: begin
        next_hold_ms = '0;
        if (both) begin
          next_state = lpc_pkg::LPC_BOTH;
        end else if (btn_eff == 2'h1 && !next_manual) begin
          next_state = lpc_pkg::LPC_TUNE;
        end
      end
      lpc_pkg::LPC_BOTH: begin
        if (!both) begin
          next_state = lpc_pkg::LPC_DONE;
          if (hold_ms >= HOLD_W_L'(FACTORY_MS)) begin
            next_factory = 1'b1;
          end else if (hold_ms >= HOLD_W_L'(RESTART_MS)) begin
            next_restart = 1'b1;
          end
        end
      end
      lpc_pkg::LPC_TUNE: begin
        if (both) begin
          next_state = lpc_pkg::LPC_BOTH;
          next_hold_ms = '0;
        end else if (btn_eff != 2'h1 || next_manual) begin
          next_state = lpc_pkg::LPC_DONE;
        end else if (tick && hold_ms == HOLD_W_L'(TUNE_MS - 1)) begin
          next_tune = 1'b1;
        end
      end
      lpc_pkg::LPC_DONE: begin
        if (btn_eff == 2'h0) begin
          next_state = lpc_pkg::LPC_IDLE;
        end
      end
      default: begin
        next_state = lpc_pkg::LPC_IDLE;
      end
    endcase
    // Flash rate from hold phase
    flashing = 1'b1;
    half = 8'(lpc_pkg::SLOW_HALF_MS);
    if (state == lpc_pkg::LPC_BOTH && hold_ms >= HOLD_W_L'(FACTORY_MS)) begin
      half = 8'(lpc_pkg::FAST_HALF_MS);
    end else if (state == lpc_pkg::LPC_BOTH && hold_ms >= HOLD_W_L'(RESTART_MS)) begin
      half = 8'(lpc_pkg::SLOW_HALF_MS);
    end else if (state == lpc_pkg::LPC_TUNE && hold_ms >= HOLD_W_L'(TUNE_MS)) begin
      half = 8'(lpc_pkg::SLOW_HALF_MS);
    end else begin
      flashing = 1'b0;
    end
    next_flash_ms = flash_ms;
    next_lamp = green_status_lamp;
    if (!flashing) begin
      next_flash_ms = 8'h00;
      next_lamp = 1'b0;
    end else if (tick) begin
      if (flash_ms >= half - 8'h01) begin
        next_flash_ms = 8'h00;
        next_lamp = !green_status_lamp;
      end else begin
        next_flash_ms = flash_ms + 8'h01;
      end
    end
  end
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      state <= lpc_pkg::LPC_IDLE;
      hold_ms <= '0;
      flash_ms <= 8'h00;
      green_status_lamp <= 1'b0;
      aerate <= 1'b0;
      deaerate <= 1'b0;
      autotune_start <= 1'b0;
      restart_req <= 1'b0;
      factory_reset_req <= 1'b0;
      manual_mode <= 1'b0;
    end else begin
      state <= next_state;
      hold_ms <= next_hold_ms;
      flash_ms <= next_flash_ms;
      green_status_lamp <= next_lamp;
      aerate <= next_aerate;
      deaerate <= next_deaerate;
      autotune_start <= next_tune;
      restart_req <= next_restart;
      factory_reset_req <= next_factory;
      manual_mode <= next_manual;
    end
  end

  // Set-point shaping: direction, characteristic, sealing
  logic [SP_W-1:0] next_setpoint;
  always_comb begin
    logic [SP_W-1:0] s_dir;
    logic [SP_W-1:0] s_inv;
    logic [2*SP_W-1:0] sq;
    logic [SP_W-1:0] s_chr;
    // Only the switch decides the direction
    s_dir = dip_eff[lpc_pkg::DIP_DIR] ? lpc_pkg::SP_FULL - sp_in : sp_in;
    s_inv = lpc_pkg::SP_FULL - s_dir;
    sq = '0;
    s_chr = s_dir;
    if (dip_eff[lpc_pkg::DIP_CHAR]) begin
      case (lpc_pkg::lpc_char_type'(char_sel))
        lpc_pkg::LPC_CHAR_EQUAL_PCT: begin
          sq = s_dir * s_dir;
          s_chr = sq[2*SP_W-1:SP_W];
        end
        lpc_pkg::LPC_CHAR_QUICK_OPEN: begin
          sq = s_inv * s_inv;
          s_chr = lpc_pkg::SP_FULL - sq[2*SP_W-1:SP_W];
        end
        default: begin
          s_chr = s_dir;
        end
      endcase
    end
    next_setpoint = s_chr;
    if (dip_eff[lpc_pkg::DIP_SEAL]) begin
      if (s_chr < seal_lo) begin
        next_setpoint = '0;
      end else if (s_chr > seal_hi) begin
        next_setpoint = lpc_pkg::SP_FULL;
      end
    end
  end
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      valve_setpoint <= '0;
    end else begin
      valve_setpoint <= next_setpoint;
    end
  end

  // Checks
  sequence s_locked;
    lock ##1 lock;
  endsequence
  a_manual_aerate: assert property (@(posedge core_clk) disable iff (!rst_b)
    dip_eff[3] && btn_eff == 2'h1 |=> aerate && !deaerate) else $error("aerate missing");
  a_manual_deaerate: assert property (@(posedge core_clk) disable iff (!rst_b)
    dip_eff[3] && btn_eff == 2'h2 |=> deaerate && !aerate) else $error("deaerate missing");
  a_auto_no_drive: assert property (@(posedge core_clk) disable iff (!rst_b)
    !dip_eff[3] |=> !aerate && !deaerate && !manual_mode) else $error("valve driven in auto");
  a_lock_freeze: assert property (@(posedge core_clk) disable iff (!rst_b)
    s_locked |-> $stable(dip_eff) && btn_eff == 2'h0) else $error("panel active while locked");
  a_restart_window: assert property (@(posedge core_clk) disable iff (!rst_b)
    $rose(restart_req) |-> $past(hold_ms) >= HOLD_W_L'(RESTART_MS) && $past(hold_ms) < HOLD_W_L'(FACTORY_MS))
    else $error("restart outside hold window");
  a_factory_hold: assert property (@(posedge core_clk) disable iff (!rst_b)
    factory_reset_req |-> $past(hold_ms) >= HOLD_W_L'(FACTORY_MS) && !restart_req)
    else $error("factory reset too early");
  a_tune_auto: assert property (@(posedge core_clk) disable iff (!rst_b)
    autotune_start |-> !manual_mode && $past(state) == lpc_pkg::LPC_TUNE) else $error("tuning start bad");
  a_dir_desc: assert property (@(posedge core_clk) disable iff (!rst_b)
    dip_eff == 4'h1 |=> valve_setpoint == lpc_pkg::SP_FULL - $past(sp_in)) else $error("descending map wrong");
  a_dir_asc: assert property (@(posedge core_clk) disable iff (!rst_b)
    dip_eff == 4'h0 |=> valve_setpoint == $past(sp_in)) else $error("ascending map wrong");
  a_seal_gate: assert property (@(posedge core_clk) disable iff (!rst_b)
    !dip_eff[1] ##1 !dip_eff[1] |-> $stable(seal_lo) && $stable(seal_hi)) else $error("seal write ungated");
endmodule

//--- src/lpc_pkg.sv
// Purpose: Shared constants and types of the local operator panel block.
// Assumes: core_clk runs at 10 MHz; set-point words are 12-bit, 0 = 4 mA, 4095 = 20 mA.
// Notes: Register offsets are byte addresses on a 32-bit APB.
package lpc_pkg;
  // Clock and time base
  localparam int CLK_HZ = 10_000_000;
  localparam int TICK_MS = 1;
  localparam int TICK_CYCLES = CLK_HZ / 1000 * TICK_MS;
  // Hold and flash times in milliseconds
  localparam int TUNE_HOLD_MS = 5000;
  localparam int RESTART_HOLD_MS = 10000;
  localparam int FACTORY_HOLD_MS = 30000;
  localparam int SLOW_FLASH_HZ = 5;
  localparam int FAST_FLASH_HZ = 10;
  localparam int SLOW_HALF_MS = 1000 / (2 * SLOW_FLASH_HZ);
  localparam int FAST_HALF_MS = 1000 / (2 * FAST_FLASH_HZ);
  localparam int DEBOUNCE_MS = 20;
  localparam int HOLD_W = 15;
  // Set-point word
  localparam int SP_W = 12;
  localparam logic [SP_W-1:0] SP_FULL = 12'hFFF;
  // Register offsets
  localparam logic [7:0] CTRL_OFS = 8'h00;
  localparam logic [7:0] SEAL_LO_OFS = 8'h04;
  localparam logic [7:0] SEAL_HI_OFS = 8'h08;
  localparam logic [7:0] CHAR_SEL_OFS = 8'h0C;
  localparam logic [7:0] STATUS_OFS = 8'h10;
  // Field positions
  localparam int CTRL_LOCK_BIT = 0;
  localparam int DIP_DIR = 0;
  localparam int DIP_SEAL = 1;
  localparam int DIP_CHAR = 2;
  localparam int DIP_MANUAL = 3;
  // Reset values: 2 % and 98 % of full scale, linear characteristic
  localparam logic [SP_W-1:0] SEAL_LO_RESET = 12'h052;
  localparam logic [SP_W-1:0] SEAL_HI_RESET = 12'hFAD;
  localparam logic [1:0] CHAR_SEL_RESET = 2'h0;
  localparam logic CTRL_LOCK_RESET = 1'b0;
  // Characteristic curves
  typedef enum logic [1:0] {
    LPC_CHAR_LINEAR,
    LPC_CHAR_EQUAL_PCT,
    LPC_CHAR_QUICK_OPEN,
    LPC_CHAR_SPARE
  } lpc_char_type;
  // Button hold sequencer
  typedef enum logic [1:0] {
    LPC_IDLE,
    LPC_BOTH,
    LPC_TUNE,
    LPC_DONE
  } lpc_hold_type;
endpackage

//--- src/lpc_debounce.sv
// Purpose: Synchronise and debounce a group of panel contacts.
// Assumes: tick is a one-cycle pulse every millisecond from core_clk logic.
// Notes: Output changes only after the synced level stays put for STABLE_TICKS ticks.
module lpc_debounce #(
  parameter int W = 6,
  parameter int STABLE_TICKS = lpc_pkg::DEBOUNCE_MS
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_b,
  // Time base
  input wire logic tick,
  // Contacts
  input wire logic [W-1:0] raw,
  output logic [W-1:0] clean
);
  genvar i;
  generate
    for (i = 0; i < W; i++) begin : g_bit
      logic sync1;
      logic sync2;
      logic [7:0] cnt;
      logic [7:0] next_cnt;
      logic next_clean;
      logic q;
      // One process owns each filtered bit
      assign clean[i] = q;
      // Count ticks while the synced level differs from the output
      always_comb begin
        next_cnt = cnt;
        next_clean = q;
        if (sync2 == q) begin
          next_cnt = 8'h00;
        end else if (tick) begin
          if (cnt >= 8'(STABLE_TICKS - 1)) begin
            next_clean = sync2;
            next_cnt = 8'h00;
          end else begin
            next_cnt = cnt + 8'h01;
          end
        end
      end
      // Two-stage synchroniser and filter state
      always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
          sync1 <= 1'b0;
          sync2 <= 1'b0;
          cnt <= 8'h00;
          q <= 1'b0;
        end else begin
          sync1 <= raw[i];
          sync2 <= sync1;
          cnt <= next_cnt;
          q <= next_clean;
        end
      end
    end
  endgenerate
endmodule

//--- testbench/lpc_operator.sv
// Purpose: Operator model that presses the panel buttons and sets the DIP switches.
// Assumes: Every change lands just after a rising core_clk edge.
// Notes: Chatter flips a contact each cycle for a burst far shorter than the debounce span.
module lpc_operator (
  // Clock
  input wire logic core_clk,
  // Panel contacts
  output logic [1:0] button_raw,
  output logic [3:0] dip_raw
);
  timeunit 1ns;
  timeprecision 1ns;

  // Contacts start released and OFF
  initial begin
    button_raw = 2'h0;
    dip_raw = 4'h0;
  end

  // Press or release buttons
  task automatic set_buttons(input logic [1:0] b);
    @(posedge core_clk);
    button_raw <= b;
  endtask

  // Move the DIP switches
  task automatic set_dip(input logic [3:0] d);
    @(posedge core_clk);
    dip_raw <= d;
  endtask

  // Contact bounce burst, then released
  task automatic chatter(input logic [1:0] b, input int n);
    repeat (n) begin
      @(posedge core_clk);
      button_raw <= button_raw ^ b;
    end
    @(posedge core_clk);
    button_raw <= 2'h0;
  endtask
endmodule

//--- testbench/local_panel_control_bench.sv
// Purpose: Self-checking bench of the local operator panel.
// Assumes: Shortened times: tick 10 cycles, tune 5, restart 10, factory 400 ticks.
// Notes: Flash half periods stay at 100 and 50 ticks, so holds are long.
module local_panel_control_bench;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int SETTLE = 300;
  typedef struct {logic [3:0] dip; logic [11:0] sp; logic [11:0] res;} lpc_row_type;
  logic core_clk, rst_b, psel, penable, pwrite, pready, pslverr, green_status_lamp;
  logic manual_mode, aerate, deaerate, autotune_start, restart_req, factory_reset_req;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [1:0] button_raw;
  logic [3:0] dip_raw;
  logic [11:0] sp_in, valve_setpoint;
  logic err, seen;
  int miscompares, compares, n_tune, n_restart, n_factory;
  lpc_row_type rows [8] = '{
    '{4'h0, 12'h123, 12'h123}, '{4'h1, 12'h123, 12'hEDC}, '{4'h0, 12'h051, 12'h051},
    '{4'h2, 12'h051, 12'h000}, '{4'h2, 12'h052, 12'h052}, '{4'h2, 12'hFAD, 12'hFAD},
    '{4'h2, 12'hFAE, 12'hFFF}, '{4'h4, 12'h123, 12'h123}};

  // Design and operator
  lpc_panel #(.TICK_CYCLES(10), .TUNE_MS(5), .RESTART_MS(10), .FACTORY_MS(400)) u_dut (
    .core_clk(core_clk), .rst_b(rst_b), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .button_raw(button_raw), .dip_raw(dip_raw), .green_status_lamp(green_status_lamp),
    .sp_in(sp_in), .valve_setpoint(valve_setpoint), .manual_mode(manual_mode), .aerate(aerate),
    .deaerate(deaerate), .autotune_start(autotune_start), .restart_req(restart_req),
    .factory_reset_req(factory_reset_req));
  lpc_operator u_op (.core_clk(core_clk), .button_raw(button_raw), .dip_raw(dip_raw));

  // Clock
  initial begin
    core_clk = 1'b0;
    forever #50 core_clk = ~core_clk;
  end

  // Pulse counters
  always @(posedge core_clk) begin
    if (autotune_start === 1'b1) n_tune++;
    if (restart_req === 1'b1) n_restart++;
    if (factory_reset_req === 1'b1) n_factory++;
  end

  task automatic check(input logic [31:0] got, input logic [31:0] want);
    compares++;
    if (got !== want) begin
      miscompares++;
      $display("wrong value at %0t: got %h expected %h", $time, got, want);
    end
  endtask

  // One APB transfer, waits for pready under a bound
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    // Let the previous release pass an edge before the next setup
    @(posedge core_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    do begin
      @(posedge core_clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) check(32'h0, 32'h1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // Lamp high time from next rise to fall, in cycles
  task automatic lamp_half(input int want);
    int n;
    n = 0;
    while (green_status_lamp !== 1'b1 && n < 3000) begin
      @(posedge core_clk);
      n++;
    end
    n = 0;
    while (green_status_lamp === 1'b1 && n < 3000) begin
      @(posedge core_clk);
      n++;
    end
    check(n, want);
  endtask

  task automatic conclude();
    $display("comparisons %0d, mismatches %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  // Watchdog
  initial begin
    repeat (80000) @(posedge core_clk);
    miscompares++;
    conclude();
  end

  // Main sequence
  initial begin
    rst_b = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    sp_in = 12'h000;
    miscompares = 0;
    compares = 0;
    n_tune = 0;
    n_restart = 0;
    n_factory = 0;
    repeat (10) @(posedge core_clk);
    check({manual_mode, aerate, valve_setpoint}, 32'h0);
    rst_b <= 1'b1;
    // Reset values and unmapped access
    apb(1'b0, lpc_pkg::CTRL_OFS, 32'h0);
    check(rd, 32'h0);
    apb(1'b0, lpc_pkg::SEAL_LO_OFS, 32'h0);
    check(rd, 32'h52);
    apb(1'b0, lpc_pkg::SEAL_HI_OFS, 32'h0);
    check(rd, 32'hFAD);
    apb(1'b0, lpc_pkg::CHAR_SEL_OFS, 32'h0);
    check(rd, 32'h0);
    apb(1'b0, 8'h14, 32'h0);
    check(err, 1'b1);
    // Writes ignored while their DIP is OFF
    apb(1'b1, lpc_pkg::SEAL_LO_OFS, 32'h100);
    apb(1'b1, lpc_pkg::CHAR_SEL_OFS, 32'h1);
    apb(1'b0, lpc_pkg::SEAL_LO_OFS, 32'h0);
    check(rd, 32'h52);
    apb(1'b0, lpc_pkg::CHAR_SEL_OFS, 32'h0);
    check(rd, 32'h0);
    // Set-point shaping table
    foreach (rows[i]) begin
      u_op.set_dip(rows[i].dip);
      repeat (SETTLE) @(posedge core_clk);
      sp_in <= rows[i].sp;
      repeat (3) @(posedge core_clk);
      check(valve_setpoint, rows[i].res);
    end
    // Square curve with DIP 3 ON
    apb(1'b1, lpc_pkg::CHAR_SEL_OFS, 32'h1);
    sp_in <= 12'h800;
    repeat (3) @(posedge core_clk);
    check(valve_setpoint, 12'h400);
    // Reprogrammed lower seal threshold
    u_op.set_dip(4'h2);
    repeat (SETTLE) @(posedge core_clk);
    apb(1'b1, lpc_pkg::SEAL_LO_OFS, 32'h100);
    sp_in <= 12'h0FF;
    repeat (3) @(posedge core_clk);
    check(valve_setpoint, 12'h000);
    // Manual state buttons
    u_op.set_dip(4'h8);
    repeat (SETTLE) @(posedge core_clk);
    check(manual_mode, 1'b1);
    u_op.set_buttons(2'h1);
    repeat (SETTLE) @(posedge core_clk);
    check({aerate, deaerate}, 2'h2);
    u_op.set_buttons(2'h2);
    repeat (SETTLE) @(posedge core_clk);
    check({aerate, deaerate}, 2'h1);
    u_op.set_buttons(2'h0);
    repeat (SETTLE) @(posedge core_clk);
    // Chatter shorter than the debounce span never aerates
    seen = 1'b0;
    fork
      u_op.chatter(2'h1, 40);
      repeat (SETTLE) begin
        @(posedge core_clk);
        if (aerate !== 1'b0) seen = 1'b1;
      end
    join
    check(seen, 1'b0);
    // Lock freezes the panel
    apb(1'b1, lpc_pkg::CTRL_OFS, 32'h1);
    apb(1'b0, lpc_pkg::STATUS_OFS, 32'h0);
    check(rd[7], 1'b1);
    u_op.set_dip(4'h0);
    u_op.set_buttons(2'h1);
    repeat (SETTLE) @(posedge core_clk);
    check({manual_mode, aerate}, 2'h2);
    u_op.set_buttons(2'h0);
    // Let the released button filter through before unlocking
    repeat (SETTLE) @(posedge core_clk);
    apb(1'b1, lpc_pkg::CTRL_OFS, 32'h0);
    repeat (SETTLE) @(posedge core_clk);
    check(manual_mode, 1'b0);
    // Auto: button 2 alone does nothing
    u_op.set_buttons(2'h2);
    repeat (SETTLE + 100) @(posedge core_clk);
    check({aerate, deaerate, green_status_lamp}, 3'h0);
    check(n_tune, 0);
    u_op.set_buttons(2'h0);
    repeat (SETTLE) @(posedge core_clk);
    // Auto: button 1 hold starts tuning, lamp at 5 Hz
    u_op.set_buttons(2'h1);
    repeat (SETTLE + 100) @(posedge core_clk);
    check(n_tune, 1);
    lamp_half(1000);
    u_op.set_buttons(2'h0);
    repeat (SETTLE) @(posedge core_clk);
    check(green_status_lamp, 1'b0);
    // Both buttons, restart window
    u_op.set_buttons(2'h3);
    lamp_half(1000);
    u_op.set_buttons(2'h0);
    repeat (SETTLE) @(posedge core_clk);
    check({n_restart[3:0], n_factory[3:0]}, 8'h10);
    // Both buttons past the factory time
    u_op.set_buttons(2'h3);
    repeat (4500) @(posedge core_clk);
    lamp_half(500);
    u_op.set_buttons(2'h0);
    repeat (SETTLE) @(posedge core_clk);
    check({n_restart[3:0], n_factory[3:0]}, 8'h11);
    // Reset in mid-run clears outputs and restores register defaults
    rst_b <= 1'b0;
    repeat (10) @(posedge core_clk);
    check({manual_mode, aerate, deaerate, green_status_lamp, valve_setpoint}, 32'h0);
    rst_b <= 1'b1;
    apb(1'b0, lpc_pkg::SEAL_LO_OFS, 32'h0);
    check(rd, 32'h52);
    apb(1'b0, lpc_pkg::CHAR_SEL_OFS, 32'h0);
    check(rd, 32'h0);
    conclude();
  end
endmodule
